// File: src/xbus_decoder_regs.vh
// Register map, address windows and timing counts of the memory decoder
`ifndef XBUS_DECODER_REGS_VH
`define XBUS_DECODER_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave
// ----------------------------------------------------------------------
`define OFS_SYSCFG 8'h00
`define OFS_PERIPH_EN 8'h04
`define OFS_WINDOW_SEL 8'h08
`define OFS_STATUS 8'h0C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SYSCFG_GLOBAL_BIT 2
`define SYSCFG_RESET 16'h0000
`define PEN_NET1_BIT 4'h0
`define PEN_NET2_BIT 4'h1
`define PEN_SRAM_BIT 4'h2
`define PEN_LRAM_BIT 4'h3
`define PEN_RTC_BIT 4'h4
`define PEN_PWM_BIT 4'h6
`define PEN_ASC_BIT 4'h7
`define PEN_SSC_BIT 4'h8
`define PEN_I2C_BIT 4'h9
`define PEN_MISC_BIT 4'hA
`define PEN_RESET 16'h0000
// Window select: low 16K block in [9:0], high 16K block in [25:16]
`define WIN_LO_RESET 10'h024
`define WIN_HI_RESET 10'h03F

// ----------------------------------------------------------------------
// Address windows (24-bit CPU address)
// ----------------------------------------------------------------------
`define FLASH_LO_END 24'h007FFF
`define FLASH_B4_BASE 24'h018000
`define FLASH_END 24'h04FFFF
`define TFLASH_END 24'h001FFF
`define BOOT_SEG1_BASE 24'h010000
`define BOOT_SEG1_END 24'h017FFF
`define SRAM_BASE 24'h00E000
`define SRAM_END 24'h00E7FF
`define PAGE_SSC 16'h00E8
`define PAGE_ASC 16'h00E9
`define PAGE_I2C 16'h00EA
`define PAGE_MISC 16'h00EB
`define PAGE_PWM 16'h00EC
`define PAGE_RTC 16'h00ED
`define PAGE_NET2 16'h00EE
`define PAGE_NET1 16'h00EF

// ----------------------------------------------------------------------
// Target codes
// ----------------------------------------------------------------------
`define TGT_EXT 4'h0
`define TGT_FLASH 4'h1
`define TGT_TFLASH 4'h2
`define TGT_SRAM 4'h3
`define TGT_LRAM 4'h4
`define TGT_NET1 4'h5
`define TGT_NET2 4'h6
`define TGT_RTC 4'h7
`define TGT_PWM 4'h8
`define TGT_ASC 4'h9
`define TGT_SSC 4'hA
`define TGT_I2C 4'hB
`define TGT_MISC 4'hC

// ----------------------------------------------------------------------
// Timing and segment masks
// ----------------------------------------------------------------------
`define PERIPH_WAIT_STATES 4'h2
`define RAM_WAIT_STATES 4'h0
`define SEG_MASK_FULL 8'hFF
`define SEG_MASK_NET 8'h0F

`endif

// File: src/wait_state_timer.v
// Wait-state counter that paces one target access
module wait_state_timer #(
    parameter WIDTH = 4
) (
    input wire hclk,
    input wire hresetn,
    input wire start,
    input wire [WIDTH-1:0] waits,
    output wire expired
);

    reg [WIDTH-1:0] count_reg;
    reg running_reg;

    // Counts the programmed waits down; expires on the last one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= {WIDTH{1'b0}};
            running_reg <= 1'b0;
        end else if (start) begin
            count_reg <= waits;
            running_reg <= 1'b1;
        end else if (running_reg) begin
            if (count_reg == {WIDTH{1'b0}}) begin
                running_reg <= 1'b0;
            end else begin
                count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Combinational so a zero-wait target finishes a cycle earlier
    assign expired = running_reg && (count_reg == {WIDTH{1'b0}});

endmodule

// File: src/onchip_memory_xbus_decoder.v
// Address decoder, peripheral enables and clock gating for the memory space
`include "xbus_decoder_regs.vh"

module onchip_memory_xbus_decoder (
    input wire hclk,
    input wire hresetn,
    // AHB-Lite register slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Strap and CPU core
    input wire bootstrap_pin,
    input wire end_of_init_instruction,
    input wire cpu_req,
    input wire [23:0] cpu_addr,
    input wire cpu_write,
    input wire cpu_byte,
    input wire cpu_stack,
    input wire cpu_bit_op,
    input wire [15:0] cpu_wdata,
    output reg [15:0] cpu_rdata,
    output wire cpu_busy,
    output reg cpu_done,
    output reg cpu_err,
    // Target side
    output reg [3:0] tgt_sel,
    output reg [2:0] flash_block,
    output reg [23:0] tgt_addr,
    output reg [15:0] tgt_wdata,
    output reg tgt_write,
    output reg tgt_byte,
    output reg tgt_strobe,
    input wire [15:0] tgt_rdata,
    input wire ext_ready,
    output reg [7:0] seg_lines_mask,
    input wire periph_reset_req,
    output reg [6:0] periph_clk_en,
    output reg [6:0] periph_reset
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    reg [15:0] system_configuration_reg;
    reg [15:0] periph_enable_register_reg;
    reg [9:0] win_lo_reg;
    reg [9:0] win_hi_reg;
    reg init_done_reg;
    reg boot_sync1_reg;
    reg boot_sync2_reg;
    reg boot_mode_reg;
    reg [1:0] boot_wait_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;

    wire global_periph_bus_enable;
    wire ahb_take;
    wire [31:0] status_word;

    assign global_periph_bus_enable =
        system_configuration_reg[`SYSCFG_GLOBAL_BIT];
    assign ahb_take = hsel && htrans[1] && hready;
    // Zero-wait slave, never an error
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Strap passes two flops; frozen at the third edge, once the pin is in
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_sync1_reg <= 1'b0;
            boot_sync2_reg <= 1'b0;
            boot_mode_reg <= 1'b0;
            boot_wait_reg <= 2'h0;
        end else begin
            boot_sync1_reg <= bootstrap_pin;
            boot_sync2_reg <= boot_sync1_reg;
            if (boot_wait_reg != 2'h3) begin
                boot_wait_reg <= boot_wait_reg + 2'h1;
                boot_mode_reg <= boot_sync2_reg;
            end
        end
    end

    // Status: init flag, boot mode, busy, segment mode and clock enables
    assign status_word = {16'h0000, periph_clk_en, 5'h00,
                          (seg_lines_mask == `SEG_MASK_NET),
                          cpu_busy, boot_mode_reg, init_done_reg};

    // Address phase: latch writes, load read data for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_reg <= ahb_take && hwrite;
            if (ahb_take) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (ahb_take && !hwrite) begin
                case (haddr[7:0])
                    `OFS_SYSCFG:
                        hrdata <= {16'h0000, system_configuration_reg};
                    `OFS_PERIPH_EN:
                        hrdata <= {16'h0000, periph_enable_register_reg};
                    `OFS_WINDOW_SEL:
                        hrdata <= {6'h00, win_hi_reg, 6'h00, win_lo_reg};
                    `OFS_STATUS:
                        hrdata <= status_word;
                    default:
                        hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Data phase writes; unmapped offsets are dropped
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_configuration_reg <= `SYSCFG_RESET;
            periph_enable_register_reg <= `PEN_RESET;
            win_lo_reg <= `WIN_LO_RESET;
            win_hi_reg <= `WIN_HI_RESET;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                `OFS_SYSCFG:
                    system_configuration_reg <= hwdata[15:0];
                `OFS_PERIPH_EN:
                    periph_enable_register_reg <= hwdata[15:0];
                `OFS_WINDOW_SEL: begin
                    win_lo_reg <= hwdata[9:0];
                    win_hi_reg <= hwdata[25:16];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Peripheral enable: global bit and own bit together
    function claims;
        input [15:0] pen;
        input glob;
        input [3:0] bitpos;
        begin
            claims = glob && pen[bitpos];
        end
    endfunction

    // One-to-one index of an 8K block inside a 32K range
    function [2:0] low_block;
        input [23:0] a;
        begin
            low_block = {1'b0, a[14:13]};
        end
    endfunction

    reg [3:0] dec_sel;
    reg [2:0] dec_block;
    reg [15:0] pen;
    reg glob;

    always @* begin
        pen = periph_enable_register_reg;
        glob = global_periph_bus_enable;
        dec_sel = `TGT_EXT;
        dec_block = 3'h0;
        if (boot_mode_reg && cpu_addr <= `TFLASH_END) begin
            dec_sel = `TGT_TFLASH;
        end else if (cpu_addr <= `FLASH_LO_END) begin
            dec_sel = `TGT_FLASH;
            dec_block = low_block(cpu_addr);
        end else if (boot_mode_reg && cpu_addr >= `BOOT_SEG1_BASE &&
                     cpu_addr <= `BOOT_SEG1_END) begin
            // Boot also maps the first four blocks into segment 1
            dec_sel = `TGT_FLASH;
            dec_block = low_block(cpu_addr);
        end else if (cpu_addr >= `FLASH_B4_BASE &&
                     cpu_addr <= `FLASH_END) begin
            dec_sel = `TGT_FLASH;
            dec_block = (cpu_addr[23:16] == 8'h01) ? 3'h4 :
                        (3'h3 + cpu_addr[18:16]);
        end else if (cpu_addr >= `SRAM_BASE && cpu_addr <= `SRAM_END) begin
            if (claims(pen, glob, `PEN_SRAM_BIT)) begin
                dec_sel = `TGT_SRAM;
            end else begin
                dec_sel = `TGT_EXT;
            end
        end else if (cpu_addr[23:14] >= win_lo_reg &&
                     cpu_addr[23:14] <= win_hi_reg) begin
            // Every 16K block in the window aliases the same RAM
            if (claims(pen, glob, `PEN_LRAM_BIT)) begin
                dec_sel = `TGT_LRAM;
            end
        end else begin
            case (cpu_addr[23:8])
                `PAGE_NET1:
                    if (claims(pen, glob, `PEN_NET1_BIT)) begin
                        dec_sel = `TGT_NET1;
                    end
                `PAGE_NET2:
                    if (claims(pen, glob, `PEN_NET2_BIT)) begin
                        dec_sel = `TGT_NET2;
                    end
                `PAGE_RTC:
                    if (claims(pen, glob, `PEN_RTC_BIT)) begin
                        dec_sel = `TGT_RTC;
                    end
                `PAGE_PWM:
                    if (claims(pen, glob, `PEN_PWM_BIT)) begin
                        dec_sel = `TGT_PWM;
                    end
                `PAGE_ASC:
                    if (claims(pen, glob, `PEN_ASC_BIT)) begin
                        dec_sel = `TGT_ASC;
                    end
                `PAGE_SSC:
                    if (claims(pen, glob, `PEN_SSC_BIT)) begin
                        dec_sel = `TGT_SSC;
                    end
                `PAGE_I2C:
                    if (claims(pen, glob, `PEN_I2C_BIT)) begin
                        dec_sel = `TGT_I2C;
                    end
                `PAGE_MISC:
                    if (claims(pen, glob, `PEN_MISC_BIT)) begin
                        dec_sel = `TGT_MISC;
                    end
                default: begin
                end
            endcase
        end
    end

    // Peripheral page targets form one contiguous code range
    function is_periph;
        input [3:0] sel;
        begin
            is_periph = (sel >= `TGT_NET1) && (sel <= `TGT_MISC);
        end
    endfunction

    function is_extension_ram;
        input [3:0] sel;
        begin
            is_extension_ram = (sel == `TGT_SRAM) || (sel == `TGT_LRAM);
        end
    endfunction

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_EXT = 2'd2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg timer_start;
    reg [3:0] timer_waits;
    wire timer_expired;
    wire bad_extension_ram_use;
    wire net_claimed;

    assign cpu_busy = (state_reg != ST_IDLE);
    // Extension RAM looks external: no stack or bit access
    assign bad_extension_ram_use = is_extension_ram(dec_sel) && (cpu_stack || cpu_bit_op);
    // Live claim, so a take right after a write masks with the new value
    assign net_claimed = claims(pen, glob, `PEN_NET1_BIT) ||
        claims(pen, glob, `PEN_NET2_BIT);

    wait_state_timer #(
        .WIDTH(4)
    ) u_wait (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(timer_start),
        .waits(timer_waits),
        .expired(timer_expired)
    );

    // Next state and the wait count to load
    always @* begin
        state_next = state_reg;
        timer_start = 1'b0;
        timer_waits = 4'h0;
        case (state_reg)
            ST_IDLE:
                if (cpu_req && !bad_extension_ram_use) begin
                    if (dec_sel == `TGT_EXT) begin
                        state_next = ST_EXT;
                    end else begin
                        state_next = ST_WAIT;
                        timer_start = 1'b1;
                        timer_waits = is_periph(dec_sel) ?
                            `PERIPH_WAIT_STATES :
                            `RAM_WAIT_STATES;
                    end
                end
            ST_WAIT:
                if (timer_expired) begin
                    state_next = ST_IDLE;
                end
            ST_EXT:
                if (ext_ready) begin
                    state_next = ST_IDLE;
                end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Launches the target access and reports completion to the core
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            tgt_sel <= `TGT_EXT;
            flash_block <= 3'h0;
            tgt_addr <= 24'h000000;
            tgt_wdata <= 16'h0000;
            tgt_write <= 1'b0;
            tgt_byte <= 1'b0;
            tgt_strobe <= 1'b0;
            cpu_rdata <= 16'h0000;
            cpu_done <= 1'b0;
            cpu_err <= 1'b0;
        end else begin
            state_reg <= state_next;
            tgt_strobe <= 1'b0;
            cpu_done <= 1'b0;
            cpu_err <= 1'b0;
            if (state_reg == ST_IDLE && cpu_req) begin
                if (bad_extension_ram_use) begin
                    cpu_err <= 1'b1;
                    cpu_done <= 1'b1;
                end else begin
                    tgt_sel <= dec_sel;
                    flash_block <= dec_block;
                    tgt_wdata <= cpu_wdata;
                    tgt_write <= cpu_write;
                    tgt_strobe <= 1'b1;
                    if (is_periph(dec_sel)) begin
                        // Pages are word wide: byte becomes a word cycle
                        tgt_addr <= {cpu_addr[23:1], 1'b0};
                        tgt_byte <= 1'b0;
                    end else begin
                        tgt_addr <= cpu_addr;
                        tgt_byte <= cpu_byte;
                    end
                    if (dec_sel == `TGT_EXT) begin
                        tgt_addr <= {cpu_addr[23:16] & (net_claimed ?
                                     `SEG_MASK_NET : `SEG_MASK_FULL),
                                     cpu_addr[15:0]};
                    end
                end
            end
            if ((state_reg == ST_WAIT && timer_expired) ||
                (state_reg == ST_EXT && ext_ready)) begin
                cpu_done <= 1'b1;
                cpu_rdata <= tgt_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Segment lines, clock gating and peripheral reset
    // ------------------------------------------------------------------
    reg [6:0] pen_vec;

    // Gatable peripherals in clock-enable order; RAMs and misc excluded
    always @* begin
        pen_vec = {periph_enable_register_reg[`PEN_I2C_BIT],
                   periph_enable_register_reg[`PEN_SSC_BIT],
                   periph_enable_register_reg[`PEN_ASC_BIT],
                   periph_enable_register_reg[`PEN_PWM_BIT],
                   periph_enable_register_reg[`PEN_RTC_BIT],
                   periph_enable_register_reg[`PEN_NET2_BIT],
                   periph_enable_register_reg[`PEN_NET1_BIT]};
    end

    // End of init is sticky; clocks run free until it arrives
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_done_reg <= 1'b0;
            periph_clk_en <= 7'h7F;
            periph_reset <= 7'h00;
            seg_lines_mask <= `SEG_MASK_FULL;
        end else begin
            if (end_of_init_instruction) begin
                init_done_reg <= 1'b1;
            end
            if (init_done_reg || end_of_init_instruction) begin
                periph_clk_en <= pen_vec;
            end else begin
                periph_clk_en <= 7'h7F;
            end
            // A gated peripheral would miss the reset anyway; hold it off
            periph_reset <= {7{periph_reset_req}} &
                ((init_done_reg || end_of_init_instruction) ?
                pen_vec : 7'h7F);
            if (net_claimed) begin
                seg_lines_mask <= `SEG_MASK_NET;
            end else begin
                seg_lines_mask <= `SEG_MASK_FULL;
            end
        end
    end

endmodule

// File: sim/target_model.sv
// Target-side responder: on-chip memories, pages and external bus
module target_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tgt_strobe,
    input wire logic [3:0] tgt_sel,
    input wire logic [23:0] tgt_addr,
    input wire logic [2:0] ext_delay,
    output logic [15:0] tgt_rdata,
    output logic ext_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    logic run_reg;
    // Data carries the target code, so a wrong route shows in the data
    assign tgt_rdata = {tgt_sel, tgt_addr[11:0]};
    // External cycle ends after a programmable stall
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_reg <= 1'b0;
            cnt_reg <= 4'h0;
            ext_ready <= 1'b0;
        end else begin
            ext_ready <= 1'b0;
            if (tgt_strobe && tgt_sel == 4'h0) begin
                run_reg <= 1'b1;
                cnt_reg <= 4'h0;
            end else if (run_reg) begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg == {1'b0, ext_delay}) begin
                    run_reg <= 1'b0;
                    ext_ready <= 1'b1;
                end
            end
        end
    end
endmodule

// File: sim/onchip_memory_xbus_decoder_assertions.sv
// Port-level checker of the memory decoder
module xbus_decoder_checker (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire end_of_init_instruction,
    input wire cpu_done,
    input wire cpu_err,
    input wire [3:0] tgt_sel,
    input wire [23:0] tgt_addr,
    input wire tgt_byte,
    input wire tgt_strobe,
    input wire [7:0] seg_lines_mask,
    input wire [6:0] periph_clk_en,
    input wire [6:0] periph_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic init_seen;
    // Sticky copy of the end-of-init pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_seen <= 1'b0;
        end else if (end_of_init_instruction) begin
            init_seen <= 1'b1;
        end
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_err_no_strobe: assert property (
        cpu_err |-> cpu_done && !tgt_strobe)
        else $error("refused access reached a target");
    chk_page_word: assert property (
        tgt_strobe && tgt_sel >= 4'h5 |-> !tgt_byte && !tgt_addr[0])
        else $error("page access not a word");
    chk_page_waits: assert property (
        tgt_strobe && tgt_sel >= 4'h5 |-> ##1 !cpu_done [*2] ##1 cpu_done)
        else $error("page access not two wait states");
    chk_ram_zero_wait: assert property (
        tgt_strobe && (tgt_sel == 4'h3 || tgt_sel == 4'h4)
        |=> cpu_done && !cpu_err)
        else $error("ram access not zero wait");
    chk_flash_done: assert property (
        tgt_strobe && (tgt_sel == 4'h1 || tgt_sel == 4'h2) |=> cpu_done)
        else $error("flash access late");
    chk_seg_masked: assert property (
        tgt_strobe && tgt_sel == 4'h0
        |-> (tgt_addr[23:16] & ~seg_lines_mask) == 8'h00)
        else $error("segment lines not masked");
    chk_gate_before: assert property (
        !init_seen |-> periph_clk_en == 7'h7F)
        else $error("clock gated before end of init");
    chk_done_pulse: assert property (cpu_done |=> !cpu_done)
        else $error("done longer than one cycle");
    chk_reset_gated: assert property (
        (periph_reset & ~periph_clk_en) == 7'h00)
        else $error("reset sent to gated peripheral");
endmodule

bind onchip_memory_xbus_decoder xbus_decoder_checker chk_u (
    .hclk, .hresetn, .hreadyout, .hresp, .end_of_init_instruction,
    .cpu_done, .cpu_err, .tgt_sel, .tgt_addr, .tgt_byte, .tgt_strobe,
    .seg_lines_mask, .periph_clk_en, .periph_reset
);

// File: sim/onchip_memory_xbus_decoder_test.sv
// Self-checking bench of the memory decoder
`include "xbus_decoder_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
module onchip_memory_xbus_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, bootstrap_pin = 0;
    logic end_of_init_instruction = 0, periph_reset_req = 0, cpu_bit_op = 0;
    logic cpu_req = 0, cpu_write = 0, cpu_byte = 0, cpu_stack = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    logic [1:0] htrans = 0;
    logic [23:0] cpu_addr = 0, tgt_addr;
    logic [15:0] cpu_rdata, tgt_rdata, tgt_wdata;
    logic hreadyout, cpu_busy, cpu_done, cpu_err, tgt_byte, tgt_strobe;
    logic ext_ready, tgt_write;
    logic [3:0] tgt_sel;
    logic [2:0] flash_block, ext_delay = 0;
    logic [7:0] seg_lines_mask;
    logic [6:0] periph_clk_en, periph_reset;
    int n_fail = 0, n_compared = 0;
    always #10 hclk = ~hclk;
    onchip_memory_xbus_decoder dut_u (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
        .bootstrap_pin, .end_of_init_instruction, .cpu_req, .cpu_addr,
        .cpu_write, .cpu_byte, .cpu_stack, .cpu_bit_op,
        .cpu_wdata(cpu_addr[15:0]), .cpu_rdata, .cpu_busy, .cpu_done,
        .cpu_err, .tgt_sel, .flash_block, .tgt_addr, .tgt_wdata, .tgt_write,
        .tgt_byte, .tgt_strobe, .tgt_rdata, .ext_ready, .seg_lines_mask,
        .periph_reset_req, .periph_clk_en, .periph_reset);
    target_model far_u (.hclk, .hresetn, .tgt_strobe, .tgt_sel, .tgt_addr,
        .ext_delay, .tgt_rdata, .ext_ready);
    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic ahb(input [7:0] a, input w, input [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        ahb(a, 1'b1, d);
    endtask
    task automatic rd(input [7:0] a, input [31:0] e);
        ahb(a, 1'b0, 32'h0);
        `CHK(r, e)
    endtask
    // Byte accesses go as writes; even addresses keep data predictable
    task automatic acc(input [23:0] a, input b, input s, input [3:0] es);
        cpu_req <= 1'b1;
        cpu_addr <= a;
        cpu_byte <= b;
        cpu_write <= b;
        cpu_stack <= s & ~b;
        cpu_bit_op <= s & b;
        do @(posedge hclk); while (cpu_busy !== 1'b0);
        cpu_req <= 1'b0;
        do @(posedge hclk); while (cpu_done !== 1'b1);
        `CHK(cpu_err, s)
        if (!s) begin
            `CHK(tgt_sel, es)
            `CHK(tgt_byte, b & (es < 4'h5))
            `CHK(cpu_rdata, {es, a[11:0]})
            `CHK({tgt_write, tgt_wdata}, {b, a[15:0]})
        end
    endtask
    task automatic rst(input b);
        hresetn <= 1'b0;
        bootstrap_pin <= b;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask
    task automatic note(input string s);
        $display("test %s finished", s);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole run is near 180 cycles; give it ample margin
    initial begin
        #100us;
        n_fail++;
        end_of_test;
    end
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst(1'b0);
        rd(`OFS_SYSCFG, 32'h0);
        rd(`OFS_PERIPH_EN, 32'h0);
        rd(`OFS_WINDOW_SEL, {6'h0, `WIN_HI_RESET, 6'h0, `WIN_LO_RESET});
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0);
        note("registers");
        acc(24'h000000, 0, 0, `TGT_FLASH);
        acc(24'h007FFE, 1, 0, `TGT_FLASH);
        acc(24'h008000, 0, 0, `TGT_EXT);
        acc(24'h018000, 0, 0, `TGT_FLASH);
        acc(24'h04FFFE, 0, 0, `TGT_FLASH);
        `CHK(flash_block, 3'h7)
        acc(24'h050000, 0, 0, `TGT_EXT);
        note("user flash");
        ext_delay <= 3'h3;
        wr(`OFS_PERIPH_EN, 32'h07DF);
        acc(24'h00E000, 0, 0, `TGT_EXT);
        acc(24'h00EF00, 0, 0, `TGT_EXT);
        acc(24'h090000, 0, 0, `TGT_EXT);
        ext_delay <= 3'h0;
        wr(`OFS_SYSCFG, 32'h0004);
        acc(24'h00E000, 1, 0, `TGT_SRAM);
        acc(24'h00E7FE, 0, 0, `TGT_SRAM);
        acc(24'h090000, 1, 0, `TGT_LRAM);
        acc(24'h0FC000, 0, 0, `TGT_LRAM);
        acc(24'h00E000, 0, 1, `TGT_SRAM);
        acc(24'h090000, 1, 1, `TGT_LRAM);
        acc(24'h00EF00, 1, 0, `TGT_NET1);
        acc(24'h00EE00, 0, 0, `TGT_NET2);
        acc(24'h00ED00, 0, 0, `TGT_RTC);
        acc(24'h00EC00, 1, 0, `TGT_PWM);
        acc(24'h00E900, 0, 0, `TGT_ASC);
        acc(24'h00E800, 0, 0, `TGT_SSC);
        acc(24'h00EA00, 0, 0, `TGT_I2C);
        acc(24'h00EB00, 0, 0, `TGT_MISC);
        acc(24'h5A0000, 0, 0, `TGT_EXT);
        `CHK(tgt_addr[23:16], 8'h0A)
        note("enabled pages");
        wr(`OFS_PERIPH_EN, 32'h0050);
        acc(24'h00EF00, 0, 0, `TGT_EXT);
        acc(24'h5A0000, 0, 0, `TGT_EXT);
        `CHK(tgt_addr[23:16], 8'h5A)
        periph_reset_req <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK(periph_reset, 7'h7F)
        end_of_init_instruction <= 1'b1;
        @(posedge hclk);
        end_of_init_instruction <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK(periph_clk_en, 7'h0C)
        `CHK(periph_reset, 7'h0C)
        periph_reset_req <= 1'b0;
        rd(`OFS_STATUS, 32'h1801);
        note("clock gating");
        rst(1'b1);
        acc(24'h000000, 0, 0, `TGT_TFLASH);
        acc(24'h010000, 0, 0, `TGT_FLASH);
        rd(`OFS_STATUS, 32'hFE02);
        note("bootstrap");
        end_of_test;
    end
endmodule
